// ### core/lvr_regs.sv
// Behaviour
// - Reference bit 0 switches reference regulator
// - Reference standby on needs bit1 and run
// - Reference sleep on needs bit2 and run
// - Reference bit 3 selects low power
// - Regulator one voltage code, five bits
// - Regulator two voltage code, four bits
// - Regulator three voltage code, five bits
// - Run enable loaded, software clear turns off
// - Bit 1 enables regulator in standby
// - Bit 2 enables regulator in sleep
// - Bit 3 low power in standby, sleep
// - Regulator one switch select only sets
// - Switch select one means fully-on switch
// - Standby default should match run enable; the memory load copies the standby bit as given
// - Reference standby default should match run; the memory load copies the standby bit as given
// - Regulator three has one-way switch select
`include "lvr_consts.svh"

module lvr_regs (
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // Power-up load from programmable memory
    input  wire logic                   prom_load,
    input  wire lvr_pkg::lvr_prom_t     prom_data,
    // Power state from the state machine
    input  wire lvr_pkg::lvr_pstate_t   pstate,
    // Drives to the power stages
    output logic                        refsup_on,
    output logic                        refsup_low_power,
    output lvr_pkg::lvr_reg_drive_t     linreg1_drive,
    output lvr_pkg::lvr_reg_drive_t     linreg2_drive,
    output lvr_pkg::lvr_reg_drive_t     linreg3_drive
);

    logic [7:0] ref_ctrl_r;
    logic [7:0] l1_volt_r;
    logic [7:0] l1_ctrl_r;
    logic [7:0] l2_volt_r;
    logic [7:0] l2_ctrl_r;
    logic [7:0] l3_volt_r;
    logic [7:0] l3_ctrl_r;
    logic [7:0] ref_ctrl_nxt;
    logic [7:0] l1_volt_nxt;
    logic [7:0] l1_ctrl_nxt;
    logic [7:0] l2_volt_nxt;
    logic [7:0] l2_ctrl_nxt;
    logic [7:0] l3_volt_nxt;
    logic [7:0] l3_ctrl_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;

    // APB decode; registers sit at byte addresses four times the index
    wire         addr_aligned = (paddr[1:0] == 2'b00);
    wire  [9:0]  word_idx     = paddr[11:2];
    wire         hit_ref      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_REF_CTRL});
    wire         hit_l1v      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L1_VOLT});
    wire         hit_l1c      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L1_CTRL});
    wire         hit_l2v      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L2_VOLT});
    wire         hit_l2c      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L2_CTRL});
    wire         hit_l3v      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L3_VOLT});
    wire         hit_l3c      = addr_aligned && (word_idx == {2'b00, `LVR_IDX_L3_CTRL});
    wire         hit_any      = hit_ref | hit_l1v | hit_l1c | hit_l2v | hit_l2c | hit_l3v | hit_l3c;
    wire         access       = psel && penable && clk_en;
    wire         setup        = psel && !penable && clk_en;
    // Only byte lane 0 holds data; other lanes are ignored
    wire         wr_en        = access && pwrite && pstrb[0] && hit_any;
    wire  [7:0]  wbyte        = pwdata[7:0];

    // Write data per register, masked so unused bits stay zero
    wire  [7:0]  ref_wr       = wbyte & `LVR_MASK_REF_CTRL;
    wire  [7:0]  l1v_wr       = wbyte & `LVR_MASK_V5;
    wire  [7:0]  l2v_wr       = wbyte & `LVR_MASK_V4;
    wire  [7:0]  l3v_wr       = wbyte & `LVR_MASK_V5;
    wire  [7:0]  l2c_wr       = wbyte & `LVR_MASK_CTRL;
    // Switch select is sticky: a written 0 cannot clear a stored 1
    wire  [7:0]  l1c_wr       = (wbyte & `LVR_MASK_CTRL_SW)
                                | (l1_ctrl_r & (8'h01 << `LVR_BIT_SWSEL));
    wire  [7:0]  l3c_wr       = (wbyte & `LVR_MASK_CTRL_SW)
                                | (l3_ctrl_r & (8'h01 << `LVR_BIT_SWSEL));

    // Next register values: load wins over a bus write in the same cycle
    always_comb begin
        ref_ctrl_nxt = ref_ctrl_r;
        l1_volt_nxt  = l1_volt_r;
        l1_ctrl_nxt  = l1_ctrl_r;
        l2_volt_nxt  = l2_volt_r;
        l2_ctrl_nxt  = l2_ctrl_r;
        l3_volt_nxt  = l3_volt_r;
        l3_ctrl_nxt  = l3_ctrl_r;
        if (prom_load) begin
            // Defaults supplied by memory; standby bits meant to mirror run, but copied here as given
            ref_ctrl_nxt = prom_data.ref_ctrl & `LVR_MASK_REF_CTRL;
            l1_volt_nxt  = prom_data.l1_volt & `LVR_MASK_V5;
            l1_ctrl_nxt  = prom_data.l1_ctrl & `LVR_MASK_CTRL_SW;
            l2_volt_nxt  = prom_data.l2_volt & `LVR_MASK_V4;
            l2_ctrl_nxt  = prom_data.l2_ctrl & `LVR_MASK_CTRL;
            l3_volt_nxt  = prom_data.l3_volt & `LVR_MASK_V5;
            l3_ctrl_nxt  = prom_data.l3_ctrl & `LVR_MASK_CTRL_SW;
        end else if (wr_en) begin
            if (hit_ref) begin
                ref_ctrl_nxt = ref_wr;
            end
            if (hit_l1v) begin
                l1_volt_nxt = l1v_wr;
            end
            if (hit_l1c) begin
                l1_ctrl_nxt = l1c_wr;
            end
            if (hit_l2v) begin
                l2_volt_nxt = l2v_wr;
            end
            if (hit_l2c) begin
                l2_ctrl_nxt = l2c_wr;
            end
            if (hit_l3v) begin
                l3_volt_nxt = l3v_wr;
            end
            if (hit_l3c) begin
                l3_ctrl_nxt = l3c_wr;
            end
        end
    end

    // Register storage, frozen while the clock enable is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_ctrl_r <= `LVR_RST_CTRL;
            l1_volt_r  <= `LVR_RST_VOLT;
            l1_ctrl_r  <= `LVR_RST_CTRL;
            l2_volt_r  <= `LVR_RST_VOLT;
            l2_ctrl_r  <= `LVR_RST_CTRL;
            l3_volt_r  <= `LVR_RST_VOLT;
            l3_ctrl_r  <= `LVR_RST_CTRL;
        end else if (clk_en) begin
            ref_ctrl_r <= ref_ctrl_nxt;
            l1_volt_r  <= l1_volt_nxt;
            l1_ctrl_r  <= l1_ctrl_nxt;
            l2_volt_r  <= l2_volt_nxt;
            l2_ctrl_r  <= l2_ctrl_nxt;
            l3_volt_r  <= l3_volt_nxt;
            l3_ctrl_r  <= l3_ctrl_nxt;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_ref) begin
            prdata_nxt = {24'h00_0000, ref_ctrl_r};
        end else if (hit_l1v) begin
            prdata_nxt = {24'h00_0000, l1_volt_r};
        end else if (hit_l1c) begin
            prdata_nxt = {24'h00_0000, l1_ctrl_r};
        end else if (hit_l2v) begin
            prdata_nxt = {24'h00_0000, l2_volt_r};
        end else if (hit_l2c) begin
            prdata_nxt = {24'h00_0000, l2_ctrl_r};
        end else if (hit_l3v) begin
            prdata_nxt = {24'h00_0000, l3_volt_r};
        end else if (hit_l3c) begin
            prdata_nxt = {24'h00_0000, l3_ctrl_r};
        end
    end

    // Read data and error captured in the setup cycle, so the access phase is one cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
            pslverr_r <= !hit_any;
        end
    end

    // Zero wait states; ready held low while frozen so no access completes unseen
    assign pready  = clk_en;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r && psel && penable;

    // Effective enable per regulator from the reported power state
    function automatic logic pick_on(input lvr_pkg::lvr_pstate_t ps,
                                     input logic [7:0]          ctrl,
                                     input logic                stby_needs_run);
        logic res;
        res = 1'b0;
        case (ps)
            lvr_pkg::LVR_PS_RUN:   res = ctrl[`LVR_BIT_RUN];
            lvr_pkg::LVR_PS_STBY:  res = ctrl[`LVR_BIT_STBY] && (ctrl[`LVR_BIT_RUN] || !stby_needs_run);
            lvr_pkg::LVR_PS_SLEEP: res = ctrl[`LVR_BIT_SLEEP] && (ctrl[`LVR_BIT_RUN] || !stby_needs_run);
            default:               res = 1'b0;
        endcase
        return res;
    endfunction

    // Low power applies only outside run for the linear regulators
    wire lin_quiet = (pstate == lvr_pkg::LVR_PS_STBY) || (pstate == lvr_pkg::LVR_PS_SLEEP);

    // Reference supply: standby and sleep both qualified by run
    logic ref_on_r;
    logic ref_lp_r;
    lvr_pkg::lvr_reg_drive_t l1_drv_r;
    lvr_pkg::lvr_reg_drive_t l2_drv_r;
    lvr_pkg::lvr_reg_drive_t l3_drv_r;

    // Registered drives to keep power-stage inputs glitch free
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_on_r <= 1'b0;
            ref_lp_r <= 1'b0;
            l1_drv_r <= '0;
            l2_drv_r <= '0;
            l3_drv_r <= '0;
        end else if (clk_en) begin
            ref_on_r <= pick_on(pstate, ref_ctrl_r, 1'b1);
            ref_lp_r <= ref_ctrl_r[`LVR_BIT_LPWR];
            l1_drv_r <= '{on:           pick_on(pstate, l1_ctrl_r, 1'b0),
                          low_power:    l1_ctrl_r[`LVR_BIT_LPWR] && lin_quiet,
                          switch_mode:  l1_ctrl_r[`LVR_BIT_SWSEL],
                          voltage_code: l1_volt_r[4:0]};
            l2_drv_r <= '{on:           pick_on(pstate, l2_ctrl_r, 1'b0),
                          low_power:    l2_ctrl_r[`LVR_BIT_LPWR] && lin_quiet,
                          switch_mode:  1'b0,
                          voltage_code: {1'b0, l2_volt_r[3:0]}};
            l3_drv_r <= '{on:           pick_on(pstate, l3_ctrl_r, 1'b0),
                          low_power:    l3_ctrl_r[`LVR_BIT_LPWR] && lin_quiet,
                          switch_mode:  l3_ctrl_r[`LVR_BIT_SWSEL],
                          voltage_code: l3_volt_r[4:0]};
        end
    end

    assign refsup_on        = ref_on_r;
    assign refsup_low_power = ref_lp_r;
    assign linreg1_drive    = l1_drv_r;
    assign linreg2_drive    = l2_drv_r;
    assign linreg3_drive    = l3_drv_r;

endmodule

// ### shared/lvr_consts.svh
`ifndef LVR_CONSTS_SVH
`define LVR_CONSTS_SVH

// Printed offsets are register indexes; byte address is four times the index
`define LVR_IDX_REF_CTRL   8'h4a
`define LVR_IDX_L1_VOLT    8'h4c
`define LVR_IDX_L1_CTRL    8'h4d
`define LVR_IDX_L2_VOLT    8'h4f
`define LVR_IDX_L2_CTRL    8'h50
`define LVR_IDX_L3_VOLT    8'h52
`define LVR_IDX_L3_CTRL    8'h53

// Control field positions
`define LVR_BIT_RUN        0
`define LVR_BIT_STBY       1
`define LVR_BIT_SLEEP      2
`define LVR_BIT_LPWR       3
`define LVR_BIT_SWSEL      4

// Writable masks per register
`define LVR_MASK_REF_CTRL  8'h0f
`define LVR_MASK_V5        8'h1f
`define LVR_MASK_V4        8'h0f
`define LVR_MASK_CTRL_SW   8'h1f
`define LVR_MASK_CTRL      8'h0f

// Reset values before the programmable-memory load
`define LVR_RST_CTRL       8'h00
`define LVR_RST_VOLT       8'h00

`endif

// ### shared/lvr_pkg.sv
package lvr_pkg;

    // Power state reported by the state machine
    typedef enum logic [2:0] {
        LVR_PS_RUN   = 3'b001,
        LVR_PS_STBY  = 3'b010,
        LVR_PS_SLEEP = 3'b100
    } lvr_pstate_t;

    // Settings loaded from programmable memory at power-up
    typedef struct packed {
        logic [7:0] ref_ctrl;
        logic [7:0] l1_volt;
        logic [7:0] l1_ctrl;
        logic [7:0] l2_volt;
        logic [7:0] l2_ctrl;
        logic [7:0] l3_volt;
        logic [7:0] l3_ctrl;
    } lvr_prom_t;

    // Drive to one regulator power stage
    typedef struct packed {
        logic       on;
        logic       low_power;
        logic       switch_mode;
        logic [4:0] voltage_code;
    } lvr_reg_drive_t;

endpackage

// ### sim/lvr_regs_asserts.sv
// Port-level checks on the regulator register bank
module lvr_regs_asserts (
    input wire logic                    mclk,
    input wire logic                    sys_rst,
    input wire logic                    clk_en,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    pslverr,
    input wire logic                    prom_load,
    input wire lvr_pkg::lvr_pstate_t    pstate,
    input wire logic                    refsup_on,
    input wire lvr_pkg::lvr_reg_drive_t linreg1_drive,
    input wire lvr_pkg::lvr_reg_drive_t linreg2_drive,
    input wire lvr_pkg::lvr_reg_drive_t linreg3_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    // Address decode and helpers, kept outside the properties
    wire        mapped = paddr inside {12'h128, 12'h130, 12'h134, 12'h13c, 12'h140, 12'h148, 12'h14c};
    wire        acc    = psel && penable && pready;
    wire        bad_ps = !(pstate inside {lvr_pkg::LVR_PS_RUN, lvr_pkg::LVR_PS_STBY, lvr_pkg::LVR_PS_SLEEP});
    wire [4:0]  wv     = pwdata[4:0];
    wire        sw1    = linreg1_drive.switch_mode;
    wire        sw3    = linreg3_drive.switch_mode;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_rdhi; prdata[31:8] == 24'h0; endproperty
    a_rdhi: assert property (p_rdhi) else $error("upper read data not zero");
    property p_rdbad; acc && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    a_rdbad: assert property (p_rdbad) else $error("unmapped read not zero");
    property p_err; psel && penable |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_l2; !linreg2_drive.switch_mode && !linreg2_drive.voltage_code[4]; endproperty
    a_l2: assert property (p_l2) else $error("second regulator extra bits set");
    property p_badps; clk_en && bad_ps |=> !refsup_on && !linreg1_drive.on && !linreg2_drive.on && !linreg3_drive.on;
    endproperty
    a_badps: assert property (p_badps) else $error("regulator on in unknown state");
    property p_lprun; clk_en && pstate == lvr_pkg::LVR_PS_RUN
        |=> !linreg1_drive.low_power && !linreg2_drive.low_power && !linreg3_drive.low_power; endproperty
    a_lprun: assert property (p_lprun) else $error("low power in run state");
    property p_swfall; $fell(sw1) || $fell(sw3) |-> $past(prom_load, 2); endproperty
    a_swfall: assert property (p_swfall) else $error("switch select cleared by bus");
    property p_wvolt; acc && pwrite && pstrb[0] && paddr == 12'h130 && !prom_load
        |=> ##1 linreg1_drive.voltage_code == $past(wv, 2); endproperty
    a_wvolt: assert property (p_wvolt) else $error("voltage code not applied");
endmodule

bind lvr_regs lvr_regs_asserts u_chk (.mclk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .prom_load, .pstate, .refsup_on, .linreg1_drive, .linreg2_drive,
    .linreg3_drive);

// ### sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    mclk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr, prom_load;
    logic                    refsup_on, refsup_low_power, re;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, rq;
    logic [3:0]              pstrb;
    lvr_pkg::lvr_prom_t      prom_data;
    lvr_pkg::lvr_pstate_t    pstate;
    lvr_pkg::lvr_reg_drive_t d1, d2, d3;
    int                      fails, compares;
    logic [11:0]             adr [7] = '{12'h128, 12'h130, 12'h134, 12'h13c, 12'h140, 12'h148, 12'h14c};
    logic [7:0]              msk [7] = '{8'h0f, 8'h1f, 8'h1f, 8'h0f, 8'h0f, 8'h1f, 8'h1f};
    lvr_pkg::lvr_pstate_t    ps [3]  = '{lvr_pkg::LVR_PS_RUN, lvr_pkg::LVR_PS_STBY, lvr_pkg::LVR_PS_SLEEP};

    lvr_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .prom_load(prom_load), .prom_data(prom_data), .pstate(pstate),
        .refsup_on(refsup_on), .refsup_low_power(refsup_low_power), .linreg1_drive(d1),
        .linreg2_drive(d2), .linreg3_drive(d3));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; idle edge after it so the next setup never collides
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        // Realign to a rising edge in case the caller last waited on a falling one
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Drives are registered, so look a full cycle later
    task settle;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task t_reset;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, adr[i], 8'h00);
            chk(rq, 32'h0);
        end
        chk({refsup_on, refsup_low_power, d1, d2, d3}, 32'h0);
        $display("test reset done");
    endtask

    // Every enable pattern against every power state
    task t_ctrl;
        logic [7:0] e;
        for (int v = 0; v < 16; v++) begin
            for (int r = 0; r < 7; r += 2) apb(1'b1, adr[r], v[7:0]);
            for (int s = 0; s < 3; s++) begin
                @(posedge mclk);
                pstate <= ps[s];
                settle();
                e[7] = v[0] & (s == 0 || v[s]);
                e[6] = v[3];
                e[5] = v[s];
                e[4] = v[3] & (s != 0);
                e[3:0] = {e[5:4], e[5:4]};
                chk({refsup_on, refsup_low_power, d1.on, d1.low_power, d2.on, d2.low_power, d3.on, d3.low_power}, e);
            end
        end
        $display("test ctrl done");
    endtask

    // Field widths, unused bits and the one-way switch select
    task t_mask;
        for (int i = 0; i < 7; i++) apb(1'b1, adr[i], 8'hff);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, adr[i], 8'h00);
            chk(rq, {24'h0, msk[i]});
        end
        settle();
        chk({d1.switch_mode, d1.voltage_code, d2.switch_mode, d2.voltage_code, d3.switch_mode, d3.voltage_code},
            {1'b1, 5'h1f, 1'b0, 5'h0f, 1'b1, 5'h1f});
        for (int i = 0; i < 7; i++) apb(1'b1, adr[i], 8'h00);
        apb(1'b0, 12'h134, 8'h00);
        chk(rq, 32'h10);
        apb(1'b0, 12'h14c, 8'h00);
        chk(rq, 32'h10);
        settle();
        chk({d1.switch_mode, d3.switch_mode}, 2'b11);
        $display("test mask done");
    endtask

    // Power-up load, masked, and a second load that may clear the switch
    task t_prom;
        prom_data <= {7{8'hff}};
        prom_load <= 1'b1;
        @(posedge mclk);
        prom_load <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, adr[i], 8'h00);
            chk(rq, {24'h0, msk[i]});
        end
        prom_data <= '0;
        prom_load <= 1'b1;
        @(posedge mclk);
        prom_load <= 1'b0;
        apb(1'b0, 12'h134, 8'h00);
        chk(rq, 32'h0);
        $display("test prom done");
    endtask

    // Unmapped, unaligned and strobe-less accesses
    task t_err;
        apb(1'b1, 12'h12c, 8'hff);
        chk(re, 1'b1);
        apb(1'b0, 12'h12c, 8'h00);
        chk({re, rq[30:0]}, 32'h80000000);
        apb(1'b0, 12'h12a, 8'h00);
        chk(re, 1'b1);
        pstrb <= 4'h0;
        apb(1'b1, 12'h130, 8'h15);
        pstrb <= 4'hf;
        apb(1'b0, 12'h130, 8'h00);
        chk(rq, 32'h0);
        $display("test err done");
    endtask

    // Undefined power state turns all off; a low clock enable freezes the drives
    task t_bad;
        for (int r = 0; r < 7; r += 2) apb(1'b1, adr[r], 8'h07);
        pstate <= lvr_pkg::LVR_PS_RUN;
        settle();
        chk({refsup_on, d1.on, d2.on, d3.on}, 4'hf);
        @(posedge mclk);
        clk_en <= 1'b0;
        pstate <= lvr_pkg::lvr_pstate_t'(3'b011);
        settle();
        chk({refsup_on, d1.on, d2.on, d3.on}, 4'hf);
        @(posedge mclk);
        clk_en <= 1'b1;
        settle();
        chk({refsup_on, d1.on, d2.on, d3.on}, 4'h0);
        @(posedge mclk);
        pstate <= lvr_pkg::LVR_PS_RUN;
        $display("test bad state done");
    endtask

    task conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; pstrb = 4'hf; prom_load = 1'b0; prom_data = '0; pstate = lvr_pkg::LVR_PS_RUN;
        fails = 0; compares = 0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_ctrl();
        t_mask();
        t_prom();
        t_err();
        t_bad();
        conclude();
    end
endmodule
